// *** shared/csmc_pkg.sv ***
package csmc_pkg;

    typedef enum logic [0:0]
    {
        CSMC_RUN = 1'h0,
        CSMC_SUSPEND = 1'h1
    } csmc_state_t;

    // Source feeding the CPU at the moment of entry
    typedef enum logic [2:0]
    {
        CSMC_SRC_FAST_OSC = 3'h0,
        CSMC_SRC_CRYSTAL_MAIN = 3'h1,
        CSMC_SRC_EXT_MAIN = 3'h2,
        CSMC_SRC_CRYSTAL_SUB = 3'h3,
        CSMC_SRC_EXT_SUB = 3'h4
    } csmc_src_t;

    // On-chip oscillators this block enables
    typedef struct packed
    {
        logic internal_fast_osc;
        logic crystal_main_clock;
        logic crystal_sub_clock;
        logic internal_slow_osc_clock;
    } csmc_osc_t;

    // Peripheral clock enables that stay on in suspend
    typedef struct packed
    {
        logic timers;
        logic serial;
        logic converter;
        logic bus_ctrl;
        logic multiplier;
        logic monitors;
        logic ext_irq;
    } csmc_periph_t;

    localparam csmc_osc_t CSMC_OSC_NONE = csmc_osc_t'(4'h0);
    localparam csmc_osc_t CSMC_OSC_FAST = csmc_osc_t'(4'h8);
    localparam csmc_osc_t CSMC_OSC_XMAIN = csmc_osc_t'(4'h4);
    localparam csmc_osc_t CSMC_OSC_XSUB = csmc_osc_t'(4'h2);
    localparam csmc_osc_t CSMC_OSC_RESET = csmc_osc_t'(4'h9);
    localparam csmc_periph_t CSMC_PERIPH_ALL = csmc_periph_t'(7'h7f);
    localparam csmc_src_t CSMC_SRC_RESET = CSMC_SRC_FAST_OSC;

endpackage : csmc_pkg

// *** hw/csmc_suspend_ctrl.sv ***
// What this block does
// - Suspend is entered only by the CPU executing the suspend instruction, never by a write.
// - Entry is accepted whichever clock source drives the CPU, main, internal fast or sub.
// - While suspended the CPU clock is gated off for every source.
// - The oscillator feeding the CPU at entry keeps running and cannot be stopped while suspended.
// - Other oscillators keep their pre-entry state, and RAM and port latches are not written.
// - The watchdog clock runs in suspend unless the option lets the slow oscillator be stopped.
`timescale 1ns/1ps

module csmc_suspend_ctrl
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic suspend_instr_i,
    input wire logic wake_i,
    input wire csmc_pkg::csmc_src_t cpu_src_i,
    input wire csmc_pkg::csmc_osc_t osc_req_i,
    input wire logic slow_osc_stoppable_i,
    output logic suspended_o,
    output logic cpu_clk_en_o,
    output csmc_pkg::csmc_osc_t osc_en_o,
    output logic wdt_clk_en_o,
    output logic flash_en_o,
    output csmc_pkg::csmc_periph_t periph_en_o,
    output logic ram_wr_en_o,
    output logic port_wr_en_o
);
    import csmc_pkg::*;

    csmc_state_t state_reg;
    csmc_state_t state_next;
    csmc_src_t src_reg;
    logic opt_reg;
    logic opt_taken_reg;
    logic opt_now;
    csmc_osc_t osc_next;

    // Oscillator that must stay on for a given CPU source
    function automatic csmc_osc_t csmc_keep_mask(input csmc_src_t src);
        csmc_osc_t m;
        m = CSMC_OSC_NONE;
        case (src)
            CSMC_SRC_FAST_OSC: m = CSMC_OSC_FAST;
            CSMC_SRC_CRYSTAL_MAIN: m = CSMC_OSC_XMAIN;
            CSMC_SRC_CRYSTAL_SUB: m = CSMC_OSC_XSUB;
            default: m = CSMC_OSC_NONE; // External inputs run as the outside drives them
        endcase
        return m;
    endfunction : csmc_keep_mask

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            CSMC_RUN:
            begin
                if (suspend_instr_i) // Instruction is the only entry path
                begin
                    state_next = CSMC_SUSPEND;
                end
            end
            CSMC_SUSPEND:
            begin
                if (wake_i)
                begin
                    state_next = CSMC_RUN;
                end
            end
            default: state_next = CSMC_RUN;
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_reg <= CSMC_RUN;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // Source latched at entry
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            src_reg <= CSMC_SRC_RESET;
        end
        else if (state_reg == CSMC_RUN)
        begin
            src_reg <= cpu_src_i;
        end
    end

    // Option strap caught once after reset release
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            opt_reg <= 1'h0;
            opt_taken_reg <= 1'h0;
        end
        else if (!opt_taken_reg)
        begin
            opt_reg <= slow_osc_stoppable_i;
            opt_taken_reg <= 1'h1;
        end
    end

    // Strap straight from the pin until it is caught, so an early entry sees it
    assign opt_now = opt_taken_reg ? opt_reg : slow_osc_stoppable_i;

    always_comb
    begin
        osc_next = osc_en_o;
        if (state_reg == CSMC_RUN && state_next == CSMC_RUN)
        begin
            osc_next = osc_req_i | csmc_keep_mask(cpu_src_i);
        end
        else if (state_reg == CSMC_RUN)
        begin
            osc_next = osc_en_o | csmc_keep_mask(cpu_src_i);
        end
        else if (state_next == CSMC_SUSPEND)
        begin
            osc_next = osc_en_o; // Requests ignored while suspended
        end
        else
        begin
            osc_next = osc_req_i | csmc_keep_mask(cpu_src_i);
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            osc_en_o <= CSMC_OSC_RESET;
        end
        else
        begin
            osc_en_o <= osc_next;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            suspended_o <= 1'h0;
            cpu_clk_en_o <= 1'h1;
            ram_wr_en_o <= 1'h1;
            port_wr_en_o <= 1'h1;
            flash_en_o <= 1'h1;
        end
        else
        begin
            suspended_o <= (state_next == CSMC_SUSPEND);
            cpu_clk_en_o <= (state_next == CSMC_RUN);
            ram_wr_en_o <= (state_next == CSMC_RUN);
            port_wr_en_o <= (state_next == CSMC_RUN);
            flash_en_o <= (state_next == CSMC_RUN);
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wdt_clk_en_o <= 1'h1;
            periph_en_o <= CSMC_PERIPH_ALL;
        end
        else
        begin
            wdt_clk_en_o <= !(state_next == CSMC_SUSPEND && opt_now);
            periph_en_o <= CSMC_PERIPH_ALL;
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    property p_no_entry_without_instr;
        state_reg == CSMC_RUN && !suspend_instr_i |=> !suspended_o;
    endproperty
    a_no_entry_without_instr: assert property (p_no_entry_without_instr)
        else $error("Suspend entered without instruction");

    property p_entry_any_src;
        state_reg == CSMC_RUN && suspend_instr_i |=> suspended_o && src_reg == $past(cpu_src_i);
    endproperty
    a_entry_any_src: assert property (p_entry_any_src)
        else $error("Suspend instruction not honoured");

    property p_cpu_gated;
        cpu_clk_en_o == (state_reg == CSMC_RUN);
    endproperty
    a_cpu_gated: assert property (p_cpu_gated)
        else $error("CPU clock not gated in suspend");

    property p_src_kept;
        suspended_o |-> (osc_en_o & csmc_keep_mask(src_reg)) == csmc_keep_mask(src_reg);
    endproperty
    a_src_kept: assert property (p_src_kept)
        else $error("Active source oscillator stopped in suspend");

    property p_osc_frozen;
        suspended_o && $past(suspended_o) |-> $stable(osc_en_o);
    endproperty
    a_osc_frozen: assert property (p_osc_frozen)
        else $error("Oscillator state changed in suspend");

    property p_mem_held;
        suspended_o |-> !ram_wr_en_o && !port_wr_en_o;
    endproperty
    a_mem_held: assert property (p_mem_held)
        else $error("RAM or port write allowed in suspend");

    property p_wdt_clk;
        suspended_o |-> wdt_clk_en_o == !opt_reg;
    endproperty
    a_wdt_clk: assert property (p_wdt_clk)
        else $error("Watchdog clock wrong in suspend");

    property p_flash_idle;
        suspended_o |-> !flash_en_o && periph_en_o == CSMC_PERIPH_ALL;
    endproperty
    a_flash_idle: assert property (p_flash_idle)
        else $error("Flash or peripheral enables wrong in suspend");

endmodule : csmc_suspend_ctrl

// *** sim/csmc_cpu_model.sv ***
`timescale 1ns/1ps

module csmc_cpu_model
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cpu_clk_en_i,
    input wire logic issue_i,
    input wire logic rogue_i,
    output logic suspend_instr_o
);
    // One-cycle pulse, only while clocked unless made rogue
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            suspend_instr_o <= 1'h0;
        end
        else
        begin
            suspend_instr_o <= issue_i && !suspend_instr_o && (cpu_clk_en_i || rogue_i);
        end
    end
endmodule : csmc_cpu_model

// *** sim/csmc_suspend_ctrl_bench.sv ***
`timescale 1ns/1ps

module csmc_suspend_ctrl_bench;
    import csmc_pkg::*;
    logic clk_i = 1'h0;
    logic rst_i = 1'h1;
    logic instr, wake_i = 1'h0, strap = 1'h0, issue = 1'h0, rogue = 1'h0;
    csmc_src_t src = CSMC_SRC_FAST_OSC;
    csmc_osc_t req = CSMC_OSC_NONE;
    logic susp_o, cpu_en, wdt_en, fl_en, ram_en, port_en;
    csmc_osc_t osc_o;
    csmc_periph_t per_o;
    logic exp_susp = 1'h0;
    csmc_osc_t exp_osc = CSMC_OSC_RESET;
    int err_total = 0, compares = 0, cycles = 0, n, pass;

    csmc_cpu_model i_cpu (.clk_i(clk_i), .rst_i(rst_i), .cpu_clk_en_i(cpu_en),
        .issue_i(issue), .rogue_i(rogue), .suspend_instr_o(instr));
    csmc_suspend_ctrl i_dut (.clk_i(clk_i), .rst_i(rst_i), .suspend_instr_i(instr),
        .wake_i(wake_i), .cpu_src_i(src), .osc_req_i(req), .slow_osc_stoppable_i(strap),
        .suspended_o(susp_o), .cpu_clk_en_o(cpu_en), .osc_en_o(osc_o),
        .wdt_clk_en_o(wdt_en), .flash_en_o(fl_en), .periph_en_o(per_o),
        .ram_wr_en_o(ram_en), .port_wr_en_o(port_en));

    initial
    begin
        forever #2.5 clk_i = ~clk_i;
    end

    function automatic csmc_osc_t keep_of(input csmc_src_t s);
        case (s)
            CSMC_SRC_FAST_OSC: return CSMC_OSC_FAST;
            CSMC_SRC_CRYSTAL_MAIN: return CSMC_OSC_XMAIN;
            CSMC_SRC_CRYSTAL_SUB: return CSMC_OSC_XSUB;
            default: return CSMC_OSC_NONE;
        endcase
    endfunction : keep_of

    task automatic chk(input string what, input logic [6:0] got, input logic [6:0] exp);
        compares++;
        if (got !== exp)
        begin
            err_total++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic results;
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
        begin
            $display("STATUS OK");
        end
        else
        begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : results

    // Reference state, sampled with the design's own edge
    always @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            exp_susp <= 1'h0;
            exp_osc <= CSMC_OSC_RESET;
        end
        else if (!exp_susp)
        begin
            exp_osc <= (instr ? exp_osc : req) | keep_of(src);
            exp_susp <= instr;
        end
        else if (wake_i)
        begin
            exp_susp <= 1'h0;
            exp_osc <= req | keep_of(src);
        end
    end

    always @(negedge clk_i)
    begin
        if (!rst_i)
        begin
            chk("mode", {6'h0, susp_o}, {6'h0, exp_susp});
            chk("cpu", {6'h0, cpu_en}, {6'h0, !exp_susp});
            chk("osc", {3'h0, osc_o}, {3'h0, exp_osc});
            chk("store", {5'h0, ram_en, port_en}, {5'h0, {2{!exp_susp}}});
            chk("wdt", {6'h0, wdt_en}, {6'h0, !(exp_susp && strap)});
            chk("flash", {6'h0, fl_en}, {6'h0, !exp_susp});
            chk("periph", per_o, CSMC_PERIPH_ALL);
        end
    end

    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            err_total++;
            results();
        end
    end

    // Random traffic, all sources, wake right after entry, rogue instructions
    initial
    begin
        void'($urandom(32'h16d5));
        repeat (4) @(posedge clk_i);
        rst_i <= 1'h0;
        for (pass = 0; pass < 2; pass++)
        begin
            repeat (3) @(posedge clk_i);
            for (n = 0; n < 800; n++)
            begin
                @(posedge clk_i);
                issue <= ($urandom % 3) == 0;
                wake_i <= ($urandom % 6) == 0;
                rogue <= n >= 600 && n < 700;
                src <= csmc_src_t'($urandom % 5);
                req <= csmc_osc_t'($urandom % 16);
            end
            @(posedge clk_i);
            issue <= 1'h0;
            wake_i <= 1'h0;
            rst_i <= 1'h1;
            strap <= !strap;
            repeat (4) @(posedge clk_i);
            rst_i <= 1'h0;
        end
        results();
    end
endmodule : csmc_suspend_ctrl_bench
